// ==== ohci_node_id_rom_map_regs_test.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("BAD %s exp %h got %h", nm, e, g); \
    end \
end
module ohci_node_id_rom_map_regs_test;
    import onrm_pkg::*;

    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wr_data = 32'h0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [31:0] rd_data;
    logic [2:0]  evt = 3'h0;
    logic        strap = 1'b0;
    logic        ee_valid, rom_rd_valid, pw_err;
    logic [63:0] ee_uid;
    logic [47:0] rom_rd_offset, pw_dest, dst;
    logic [15:0] pw_src_id, src;
    logic        rom_host_valid, uid_locked, rd_d = 1'b0;
    logic [31:0] rom_host_addr, d, base, a, b, note;
    logic [63:0] e;
    logic [9:0]  k;
    logic [31:0] exp_rd[$], exp_rom[$];
    int          failures = 0;
    int          num_checks = 0;

    always #10 clock = ~clock;

    onrm_regs onrm_regs_i (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .soft_reset(evt[0]), .bus_reset(evt[1]), .rom_change(evt[2]),
        .eeprom_present_pin(strap), .eeprom_uid_valid(ee_valid),
        .eeprom_uid(ee_uid), .rom_rd_valid(rom_rd_valid),
        .rom_rd_offset(rom_rd_offset), .rom_host_valid(rom_host_valid),
        .rom_host_addr(rom_host_addr), .pw_err(pw_err),
        .pw_src_id(pw_src_id), .pw_dest(pw_dest), .uid_locked(uid_locked)
    );

    onrm_far_node onrm_far_node_i (
        .clock(clock), .rom_rd_valid(rom_rd_valid),
        .rom_rd_offset(rom_rd_offset), .pw_err(pw_err),
        .pw_src_id(pw_src_id), .pw_dest(pw_dest),
        .ee_valid(ee_valid), .ee_uid(ee_uid)
    );

    // ************************************************************
    // bus master and event tasks
    // ************************************************************
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clock);
        wr_stb  <= 1'b1;
        addr    <= ad;
        wr_data <= dt;
        @(posedge clock);
        wr_stb  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
        @(posedge clock);
        rd_stb <= 1'b1;
        addr   <= ad;
        exp_rd.push_back(ex);
        @(posedge clock);
        rd_stb <= 1'b0;
    endtask

    task automatic ev(input logic [2:0] m);
        @(posedge clock);
        evt <= m;
        @(posedge clock);
        evt <= 3'h0;
    endtask

    task automatic rst(input logic s);
        @(posedge clock);
        rst_n <= 1'b0;
        strap <= s;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // monitor: oldest note against each result
    // ************************************************************
    always @(posedge clock) rd_d <= rd_stb;

    always @(negedge clock) begin
        if (rd_d) begin
            if (exp_rd.size() == 0) `CHK("rd_note", 1'b1, 1'b0)
            else begin
                note = exp_rd.pop_front();
                `CHK("rd_data", note, rd_data)
            end
        end else
            `CHK("rd_idle", RD_IDLE, rd_data)
        if (rom_host_valid === 1'b1) begin
            if (exp_rom.size() == 0) `CHK("rom_miss", 1'b0, 1'b1)
            else begin
                note = exp_rom.pop_front();
                `CHK("rom_addr", note, rom_host_addr)
            end
        end
    end

    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(51));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        rd(OFS_BUS_OPT, {24'h0, GEN_RST, 3'h0, LNK_SPD_VAL});
        rd(OFS_UID_HI, UID_RST);
        rd(OFS_UID_LO, UID_RST);
        rd(OFS_ROM_MAP, ROM_MAP_RST);
        rd(OFS_CAP_LO, CAP_RST);
        rd(OFS_CAP_HI, CAP_RST);
        rd(8'h44, RD_IDLE);
        wr(OFS_BUS_OPT, 32'hffff_ffff);
        rd(OFS_BUS_OPT, 32'h0000_00c2);
        wr(OFS_BUS_OPT, 32'h0000_0000);
        ev(3'h4);
        ev(3'h2);
        rd(OFS_BUS_OPT, 32'h0000_0042);
        ev(3'h2);
        rd(OFS_BUS_OPT, 32'h0000_0042);
        d = $urandom();
        base = {d[31:10], 10'h0};
        wr(OFS_ROM_MAP, d);
        rd(OFS_ROM_MAP, base);
        for (int i = 0; i < 4; i++) begin
            k = (i == 0) ? 10'h0 : (i == 1) ? 10'h3ff : 10'($urandom());
            exp_rom.push_back(base + {22'h0, k});
            onrm_far_node_i.rom_read(ROM_WIN_LO + {38'h0, k});
        end
        onrm_far_node_i.rom_read(ROM_WIN_LO - 48'h1);
        onrm_far_node_i.rom_read(ROM_WIN_HI + 48'h1);
        src = 16'($urandom());
        dst = {16'($urandom()), 32'($urandom())};
        onrm_far_node_i.post_fail(src, dst);
        rd(OFS_CAP_LO, dst[31:0]);
        rd(OFS_CAP_HI, {src, dst[47:32]});
        wr(OFS_CAP_LO, ~dst[31:0]);
        rd(OFS_CAP_LO, dst[31:0]);
        a = $urandom();
        b = $urandom();
        wr(OFS_UID_HI, a);
        wr(OFS_UID_LO, b);
        wr(OFS_UID_HI, ~a);
        wr(OFS_UID_LO, ~b);
        rd(OFS_UID_HI, a);
        rd(OFS_UID_LO, b);
        @(negedge clock);
        `CHK("uid_locked", 1'b1, uid_locked)
        ev(3'h1);
        rd(OFS_UID_HI, a);
        rd(OFS_UID_LO, b);
        rd(OFS_ROM_MAP, ROM_MAP_RST);
        rst(1'b1);
        rd(OFS_UID_HI, UID_RST);
        @(negedge clock);
        `CHK("uid_locked", 1'b0, uid_locked)
        wr(OFS_UID_HI, a);
        rd(OFS_UID_HI, UID_RST);
        e = {$urandom(), $urandom()};
        onrm_far_node_i.ee_load(e);
        rd(OFS_UID_HI, e[63:32]);
        rd(OFS_UID_LO, e[31:0]);
        @(negedge clock);
        `CHK("uid_locked", 1'b1, uid_locked)
        onrm_far_node_i.ee_load(~e);
        wr(OFS_UID_LO, b);
        rd(OFS_UID_LO, e[31:0]);
        repeat (4) @(posedge clock);
        tally_and_finish();
    end
endmodule

// ==== onrm_far_node.sv ====
`timescale 1ns/100ps
module onrm_far_node (
    // clock
    input  wire logic clock,
    // config rom quadlet read from a remote node
    output logic        rom_rd_valid,
    output logic [47:0] rom_rd_offset,
    // posted write that failed
    output logic        pw_err,
    output logic [15:0] pw_src_id,
    output logic [47:0] pw_dest,
    // serial eeprom loader
    output logic        ee_valid,
    output logic [63:0] ee_uid
);
    initial begin
        rom_rd_valid  = 1'b0;
        rom_rd_offset = 48'h0;
        pw_err        = 1'b0;
        pw_src_id     = 16'h0;
        pw_dest       = 48'h0;
        ee_valid      = 1'b0;
        ee_uid        = 64'h0;
    end

    // ************************************************************
    // one-cycle requests; released lines show the inverse value
    // ************************************************************
    task automatic rom_read(input logic [47:0] ofs);
        @(posedge clock);
        rom_rd_valid  <= 1'b1;
        rom_rd_offset <= ofs;
        @(posedge clock);
        rom_rd_valid  <= 1'b0;
        rom_rd_offset <= ~ofs;
    endtask

    task automatic post_fail(input logic [15:0] src,
                             input logic [47:0] dst);
        @(posedge clock);
        pw_err    <= 1'b1;
        pw_src_id <= src;
        pw_dest   <= dst;
        @(posedge clock);
        pw_err    <= 1'b0;
        pw_src_id <= ~src;
        pw_dest   <= ~dst;
    endtask

    task automatic ee_load(input logic [63:0] uid);
        @(posedge clock);
        ee_valid <= 1'b1;
        ee_uid   <= uid;
        @(posedge clock);
        ee_valid <= 1'b0;
        ee_uid   <= ~uid;
    endtask
endmodule

// ==== onrm_pkg.sv ====
package onrm_pkg;

    // ************************************************************
    // bus and register map
    // ************************************************************
    localparam int          AW           = 8;
    localparam int          DW           = 32;
    localparam logic [7:0]  OFS_BUS_OPT  = 8'h20;
    localparam logic [7:0]  OFS_UID_HI   = 8'h24;
    localparam logic [7:0]  OFS_UID_LO   = 8'h28;
    localparam logic [7:0]  OFS_ROM_MAP  = 8'h34;
    localparam logic [7:0]  OFS_CAP_LO   = 8'h38;
    localparam logic [7:0]  OFS_CAP_HI   = 8'h3c;

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int          GEN_LSB      = 6;
    localparam int          GEN_W        = 2;
    localparam int          LNK_SPD_LSB  = 0;
    localparam int          LNK_SPD_W    = 3;
    localparam logic [2:0]  LNK_SPD_VAL  = 3'h2;
    localparam int          ROM_BASE_LSB = 10;
    localparam int          ROM_OFS_W    = 10;
    localparam int          SRC_ID_W     = 16;
    localparam int          DEST_W       = 48;

    // ************************************************************
    // config rom window seen from the 1394 side
    // ************************************************************
    localparam logic [47:0] ROM_WIN_LO   = 48'hffff_f000_0400;
    localparam logic [47:0] ROM_WIN_HI   = 48'hffff_f000_07ff;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] UID_RST      = 32'h0000_0000;
    localparam logic [31:0] ROM_MAP_RST  = 32'h0000_0000;
    localparam logic [1:0]  GEN_RST      = 2'h0;
    localparam logic [31:0] CAP_RST      = 32'h0000_0000;
    localparam logic [31:0] RD_IDLE      = 32'h0000_0000;

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

endpackage

// ==== onrm_regs.sv ====
// Local design decision: strobed register access.
`timescale 1ns/100ps
// How it works
// [R1] bus options bits 11:8 read zero
// [R2] generation count bumps on bus reset if changed
// [R3] bus options bits 5:3 read zero
// [R4] link speed always reads 010
// [R5] upper unique id word, reset zero
// [R6] eeprom loads unique id once, then locked
// [R7] without eeprom firmware loads once, then locked
// [R8] unique id cleared only by global reset
// [R9] lower unique id word behaves identically
// [R10] rom window read adds offset to base
// [R11] rom base bits 31:10, 9:0 read zero
// [R12] posted write error captures request info
// [R13] low capture holds dest offset low bits
// [R14] high capture holds source id, upper offset
// [R15] writes to read-only fields are ignored
module onrm_regs
    import onrm_pkg::*;
(
    // clock and global reset
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    // register port
    input  wire logic [onrm_pkg::AW-1:0]   addr,
    input  wire logic [onrm_pkg::DW-1:0]   wr_data,
    input  wire logic                      wr_stb,
    input  wire logic                      rd_stb,
    output logic      [onrm_pkg::DW-1:0]   rd_data,
    // link events
    input  wire logic                      soft_reset,
    input  wire logic                      bus_reset,
    input  wire logic                      rom_change,
    // serial eeprom
    input  wire logic                      eeprom_present_pin,
    input  wire logic                      eeprom_uid_valid,
    input  wire logic [63:0]               eeprom_uid,
    // config rom read from the 1394 side
    input  wire logic                      rom_rd_valid,
    input  wire logic [onrm_pkg::DEST_W-1:0] rom_rd_offset,
    output logic                           rom_host_valid,
    output logic      [31:0]               rom_host_addr,
    // posted write failure
    input  wire logic                      pw_err,
    input  wire logic [onrm_pkg::SRC_ID_W-1:0] pw_src_id,
    input  wire logic [onrm_pkg::DEST_W-1:0] pw_dest,
    // unique id state
    output logic                           uid_locked
);
    import onrm_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [DW-1:0]     rd_data_r;
    logic [DW-1:0]     rd_data_nxt;
    logic [GEN_W-1:0]  gen_r;
    logic [GEN_W-1:0]  gen_nxt;
    logic              changed_r;
    logic              changed_nxt;
    logic [31:ROM_BASE_LSB] rom_base_r;
    logic [31:ROM_BASE_LSB] rom_base_nxt;
    logic              rom_host_valid_r;
    logic [31:0]       rom_host_addr_r;
    logic [31:0]       cap_lo_r;
    logic [31:0]       cap_hi_r;
    logic              uid_locked_r;
    logic              eeprom_present;
    logic [31:0]       uid_hi;
    logic [31:0]       uid_lo;
    logic              uid_hi_locked;
    logic              uid_lo_locked;
    logic              hit_bus_opt;
    logic              hit_uid_hi;
    logic              hit_uid_lo;
    logic              hit_rom_map;
    logic              hit_cap_lo;
    logic              hit_cap_hi;
    logic              wr_gen;
    logic              wr_rom;
    logic              ee_ld;
    logic              fw_ld_hi;
    logic              fw_ld_lo;
    logic              ld_hi;
    logic              ld_lo;
    logic [31:0]       ld_hi_data;
    logic [31:0]       ld_lo_data;
    logic              rom_hit;
    logic [31:0]       rom_base_word;
    logic [31:0]       rom_sum;
    logic [DW-1:0]     bus_opt_word;
    logic [31:0]       cap_hi_word;

    // ************************************************************
    // address decode
    // ************************************************************
    assign hit_bus_opt = reg_hit(addr, OFS_BUS_OPT);
    assign hit_uid_hi  = reg_hit(addr, OFS_UID_HI);
    assign hit_uid_lo  = reg_hit(addr, OFS_UID_LO);
    assign hit_rom_map = reg_hit(addr, OFS_ROM_MAP);
    assign hit_cap_lo  = reg_hit(addr, OFS_CAP_LO);
    assign hit_cap_hi  = reg_hit(addr, OFS_CAP_HI);
    assign wr_gen      = wr_stb && hit_bus_opt;
    assign wr_rom      = wr_stb && hit_rom_map;

    // ************************************************************
    // unique id words
    // ************************************************************
    onrm_sync3 u_sync_ee (
        .clock (clock),
        .rst_n (rst_n),
        .d     (eeprom_present_pin),
        .q     (eeprom_present)
    );

    assign ee_ld      = eeprom_uid_valid && eeprom_present;      // [R6]
    assign fw_ld_hi   = wr_stb && hit_uid_hi && !eeprom_present; // [R7]
    assign fw_ld_lo   = wr_stb && hit_uid_lo && !eeprom_present; // [R7]
    assign ld_hi      = ee_ld || fw_ld_hi;
    assign ld_lo      = ee_ld || fw_ld_lo;
    assign ld_hi_data = ee_ld ? eeprom_uid[63:32] : wr_data;
    assign ld_lo_data = ee_ld ? eeprom_uid[31:0] : wr_data;

    // only rst_n reaches these words, soft_reset does not [R8]
    onrm_uid_word u_uid_hi (                                     // [R5]
        .clock   (clock),
        .rst_n   (rst_n),
        .ld_en   (ld_hi),
        .ld_data (ld_hi_data),
        .value   (uid_hi),
        .locked  (uid_hi_locked)
    );

    onrm_uid_word u_uid_lo (                                     // [R9]
        .clock   (clock),
        .rst_n   (rst_n),
        .ld_en   (ld_lo),
        .ld_data (ld_lo_data),
        .value   (uid_lo),
        .locked  (uid_lo_locked)
    );

    // ************************************************************
    // bus options: generation count
    // ************************************************************
    // a change seen during a bus reset survives to the next one
    assign changed_nxt = rom_change || (changed_r && !bus_reset); // [R2]

    always_comb begin
        gen_nxt = gen_r;
        if (soft_reset) begin
            gen_nxt = GEN_RST;
        end else if (bus_reset && changed_r) begin
            gen_nxt = GEN_W'(gen_r + 2'h1);                      // [R2]
        end else if (wr_gen) begin
            gen_nxt = wr_data[GEN_LSB +: GEN_W];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gen_r     <= GEN_RST;
            changed_r <= 1'b0;
        end else begin
            gen_r     <= gen_nxt;
            changed_r <= soft_reset ? 1'b0 : changed_nxt;
        end
    end

    // reserved and upper bits read zero, speed code fixed [R1] [R3] [R4]
    always_comb begin
        bus_opt_word = '0;
        bus_opt_word[GEN_LSB +: GEN_W] = gen_r;
        bus_opt_word[LNK_SPD_LSB +: LNK_SPD_W] = LNK_SPD_VAL;
    end

    // ************************************************************
    // config rom mapping
    // ************************************************************
    assign rom_base_nxt  = soft_reset ? ROM_MAP_RST[31:ROM_BASE_LSB]
                         : wr_rom ? wr_data[31:ROM_BASE_LSB]
                         : rom_base_r;
    assign rom_base_word = {rom_base_r, {ROM_BASE_LSB{1'b0}}};   // [R11]
    assign rom_hit       = rom_rd_valid
                         && (rom_rd_offset >= ROM_WIN_LO)
                         && (rom_rd_offset <= ROM_WIN_HI);
    assign rom_sum       = rom_base_word
                         + {22'h0, rom_rd_offset[ROM_OFS_W-1:0]}; // [R10]

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rom_base_r       <= ROM_MAP_RST[31:ROM_BASE_LSB];
            rom_host_valid_r <= 1'b0;
            rom_host_addr_r  <= ROM_MAP_RST;
        end else begin
            rom_base_r       <= rom_base_nxt;
            rom_host_valid_r <= rom_hit;                         // [R10]
            if (rom_hit) begin
                rom_host_addr_r <= rom_sum;
            end
        end
    end

    // ************************************************************
    // posted write failure capture
    // ************************************************************
    assign cap_hi_word = {pw_src_id, pw_dest[47:32]};           // [R14]

    // hardware alone updates these, bus writes never reach them [R15]
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cap_lo_r <= CAP_RST;
            cap_hi_r <= CAP_RST;
        end else if (pw_err) begin                              // [R12]
            cap_lo_r <= pw_dest[31:0];                           // [R13]
            cap_hi_r <= cap_hi_word;                             // [R14]
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    always_comb begin
        rd_data_nxt = RD_IDLE;
        if (rd_stb) begin
            if (hit_bus_opt) rd_data_nxt = bus_opt_word;
            if (hit_uid_hi) rd_data_nxt = uid_hi;
            if (hit_uid_lo) rd_data_nxt = uid_lo;
            if (hit_rom_map) rd_data_nxt = rom_base_word;         // [R11]
            if (hit_cap_lo) rd_data_nxt = cap_lo_r;
            if (hit_cap_hi) rd_data_nxt = cap_hi_r;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r    <= RD_IDLE;
            uid_locked_r <= 1'b0;
        end else begin
            rd_data_r    <= rd_data_nxt;
            uid_locked_r <= uid_hi_locked && uid_lo_locked;
        end
    end

    assign rd_data        = rd_data_r;
    assign rom_host_valid = rom_host_valid_r;
    assign rom_host_addr  = rom_host_addr_r;
    assign uid_locked     = uid_locked_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_opt_read;
        rd_stb && hit_bus_opt;
    endsequence

    sequence s_fw_write_hi;
        wr_stb && hit_uid_hi && !eeprom_present && !uid_hi_locked;
    endsequence

    property p_rsvd_zero;
        s_opt_read |=> (rd_data[11:8] == 4'h0) && (rd_data[5:3] == 3'h0);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) // [R1] [R3]
        else $error("reserved bus option bits not zero");

    property p_lnk_spd;
        s_opt_read |=> rd_data[2:0] == 3'h2;
    endproperty
    a_lnk_spd: assert property (p_lnk_spd) // [R4]
        else $error("link speed code wrong");

    property p_gen_inc;
        bus_reset && changed_r && !soft_reset
            |=> gen_r == GEN_W'($past(gen_r) + 2'h1);
    endproperty
    a_gen_inc: assert property (p_gen_inc) // [R2]
        else $error("generation count did not advance");

    property p_gen_hold;
        bus_reset && !changed_r && !soft_reset && !wr_gen |=> $stable(gen_r);
    endproperty
    a_gen_hold: assert property (p_gen_hold) // [R2]
        else $error("generation count moved without change");

    property p_uid_zero;
        !uid_hi_locked |-> uid_hi == 32'h0;
    endproperty
    a_uid_zero: assert property (p_uid_zero) // [R5]
        else $error("unique id nonzero before load");

    property p_ee_load;
        ee_ld && !uid_lo_locked
            |=> uid_lo == $past(eeprom_uid[31:0]) ##1 uid_lo_locked;
    endproperty
    a_ee_load: assert property (p_ee_load) // [R6] [R9]
        else $error("eeprom load of unique id failed");

    property p_fw_load;
        s_fw_write_hi |=> (uid_hi == $past(wr_data)) && uid_hi_locked
            ##1 uid_locked_r == $past(uid_lo_locked);
    endproperty
    a_fw_load: assert property (p_fw_load) // [R7]
        else $error("firmware load of unique id failed");

    property p_uid_frozen;
        uid_hi_locked && uid_lo_locked |=> $stable(uid_hi) && $stable(uid_lo);
    endproperty
    a_uid_frozen: assert property (p_uid_frozen) // [R6] [R7] [R8]
        else $error("locked unique id changed");

    property p_rom_addr;
        rom_hit |=> rom_host_valid
            && rom_host_addr == $past(rom_base_word)
               + {22'h0, $past(rom_rd_offset[9:0])};
    endproperty
    a_rom_addr: assert property (p_rom_addr) // [R10]
        else $error("rom host address wrong");

    property p_rom_miss;
        !rom_hit |=> !rom_host_valid;
    endproperty
    a_rom_miss: assert property (p_rom_miss) // [R10]
        else $error("rom host valid without window hit");

    property p_rom_rsvd;
        rd_stb && hit_rom_map |=> rd_data[9:0] == 10'h000;
    endproperty
    a_rom_rsvd: assert property (p_rom_rsvd) // [R11]
        else $error("rom map low bits not zero");

    property p_capture;
        pw_err |=> cap_lo_r == $past(pw_dest[31:0])
            && cap_hi_r == {$past(pw_src_id), $past(pw_dest[47:32])};
    endproperty
    a_capture: assert property (p_capture) // [R12] [R13] [R14]
        else $error("posted write capture wrong");

    property p_ro_ignore;
        wr_stb && (hit_cap_lo || hit_cap_hi) && !pw_err
            |=> $stable(cap_lo_r) && $stable(cap_hi_r);
    endproperty
    a_ro_ignore: assert property (p_ro_ignore) // [R15]
        else $error("write reached a read-only capture");

endmodule

// ==== onrm_sync3.sv ====
`timescale 1ns/100ps
module onrm_sync3 (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // pin in, filtered level out
    input  wire logic d,
    output logic      q
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic q_r;

    // level moves only once stages two and three agree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_r  <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q_r <= s3_r;
            end
        end
    end

    assign q = q_r;
endmodule

// ==== onrm_uid_word.sv ====
`timescale 1ns/100ps
module onrm_uid_word
    import onrm_pkg::*;
(
    // clock and global reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // one-time load
    input  wire logic        ld_en,
    input  wire logic [31:0] ld_data,
    // stored word
    output logic      [31:0] value,
    output logic             locked
);
    logic [31:0] value_r;
    logic        locked_r;
    logic        take;

    assign take = ld_en && !locked_r;

    // first load wins, then the word is frozen until global reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value_r  <= UID_RST;
            locked_r <= 1'b0;
        end else if (take) begin
            value_r  <= ld_data;
            locked_r <= 1'b1;
        end
    end

    assign value  = value_r;
    assign locked = locked_r;
endmodule
